//--- cnv_pkg.sv
// Purpose: shared constants for the converter configuration page zero
// Assumes: byte-wide registers reached by a serial byte protocol
// Notes:   field positions and reset values are named once here
package cnv_pkg;
    localparam int CNV_DATA_W  = 8;
    localparam int CNV_ADDR_W  = 5;
    localparam int CNV_PAGE_W  = 3;
    localparam int CNV_NREG    = 16;
    localparam int CNV_FREQ_W  = 40;
    localparam int CNV_PHASE_W = 13;
    localparam int CNV_GAIN_W  = 12;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [4:0] CNV_OFS_COMMON = 5'h00;
    localparam logic [4:0] CNV_OFS_TRANSMIT_CONFIG  = 5'h01;
    localparam logic [4:0] CNV_OFS_MULCFG = 5'h02;
    localparam logic [4:0] CNV_OFS_SPARE  = 5'h03;
    localparam logic [4:0] CNV_OFS_FREQ0  = 5'h04;
    localparam logic [4:0] CNV_OFS_FREQ4  = 5'h08;
    localparam logic [4:0] CNV_OFS_PHLO   = 5'h09;
    localparam logic [4:0] CNV_OFS_PHHI   = 5'h0a;
    localparam logic [4:0] CNV_OFS_AGLO   = 5'h0b;
    localparam logic [4:0] CNV_OFS_AGHI   = 5'h0c;
    localparam logic [4:0] CNV_OFS_BGLO   = 5'h0d;
    localparam logic [4:0] CNV_OFS_BGHI   = 5'h0e;
    localparam logic [4:0] CNV_OFS_OUTCTL = 5'h0f;
    localparam logic [4:0] CNV_OFS_PAGE   = 5'h1f;

    ////////////////////////////////////////////////////////////////////////////
    localparam int CNV_COM_WIRE = 7;
    localparam int CNV_COM_RST  = 6;
    localparam int CNV_COM_FMT  = 2;
    localparam int CNV_COM_CHIP = 1;
    localparam int CNV_COM_GAP  = 0;
    localparam int CNV_TX_OSC   = 7;
    localparam int CNV_TX_LPOSC = 6;
    localparam int CNV_TX_ISINC = 5;
    localparam int CNV_TX_MOD   = 2;
    localparam int CNV_TX_INTP  = 0;
    localparam int CNV_MU_BYP   = 7;
    localparam int CNV_MU_BUF   = 6;
    localparam int CNV_MU_LOOP  = 5;
    localparam int CNV_MU_DIV   = 3;
    localparam int CNV_MU_PH    = 1;
    localparam int CNV_MU_OSC   = 0;
    localparam int CNV_PH_EN    = 7;
    localparam int CNV_OC_AGE   = 3;
    localparam int CNV_OC_BGE   = 2;
    localparam int CNV_OC_ATT   = 1;
    localparam int CNV_OC_CLIP  = 0;
    localparam int CNV_LP_LSB   = 3;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] CNV_RST_VAL [CNV_NREG] = '{
        8'h87, 8'h01, 8'ha1, 8'h00, 8'h66, 8'h66, 8'h66, 8'h66,
        8'h26, 8'h00, 8'h00, 8'h50, 8'h0b, 8'h50, 8'h0b, 8'h00};
    localparam logic [7:0] CNV_WR_MASK [CNV_NREG] = '{
        8'hc7, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h9f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h0f};
    localparam logic [2:0] CNV_PAGE_RST = 3'h0;
endpackage : cnv_pkg

//--- cnv_serial_link.sv
// Purpose: serial byte link, one instruction byte then one data byte
// Assumes: link pins are synchronous to sys_clk and much slower than it
// Notes:   instruction bit 7 high = read, bits 4:0 = offset; mode 0 timing
`timescale 1ns/1ps
module cnv_serial_link
    import cnv_pkg::*;
(
    input  wire logic                      sys_clk,   // system clock
    input  wire logic                      rst_b,     // async reset, active low
    input  wire logic                      serClk,    // serial clock pin
    input  wire logic                      serSelB,   // frame select, active low
    input  wire logic                      serIn,     // serial data in
    output logic                           serOut,    // serial data out
    output logic                           serDrive,  // read data phase
    output logic [cnv_pkg::CNV_ADDR_W-1:0] regAddr,   // latched offset
    input  wire logic [cnv_pkg::CNV_DATA_W-1:0] rdData, // read value
    output logic                           wrStrobe,  // one-cycle write
    output logic [cnv_pkg::CNV_DATA_W-1:0] wrData     // write value
);
    logic       clkPrev_reg;
    logic [4:0] bitCnt_reg;
    logic [6:0] inShift_reg;
    logic [7:0] outShift_reg;
    logic       isRead_reg;

    wire        rise     = serClk & ~clkPrev_reg & ~serSelB;
    wire        fall     = ~serClk & clkPrev_reg & ~serSelB;
    wire [7:0]  inByte   = {inShift_reg, serIn};
    wire        instrEnd = rise && (bitCnt_reg == 5'd7);
    wire        dataEnd  = rise && (bitCnt_reg == 5'd15);
    wire        loadOut  = fall && (bitCnt_reg == 5'd8) && isRead_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clkPrev_reg  <= 1'b0;
            bitCnt_reg   <= 5'd0;
            inShift_reg  <= 7'h00;
            outShift_reg <= 8'h00;
            isRead_reg   <= 1'b0;
            regAddr      <= '0;
            serDrive     <= 1'b0;
            wrStrobe     <= 1'b0;
            wrData       <= '0;
        end else begin
            clkPrev_reg <= serClk;
            wrStrobe    <= dataEnd & ~isRead_reg;
            if (serSelB) begin
                bitCnt_reg <= 5'd0;
                serDrive   <= 1'b0;
            end else if (rise && bitCnt_reg < 5'd16) begin
                bitCnt_reg  <= bitCnt_reg + 5'd1;
                inShift_reg <= inByte[6:0];
            end
            if (instrEnd) begin
                isRead_reg <= inByte[7];
                regAddr    <= inByte[4:0];
            end
            if (dataEnd)
                wrData <= inByte;
            if (loadOut) begin
                outShift_reg <= rdData;
                serDrive     <= 1'b1;
            end else if (fall && bitCnt_reg > 5'd8)
                outShift_reg <= {outShift_reg[6:0], 1'b0};
        end
    end

    assign serOut = outShift_reg[7];
endmodule : cnv_serial_link

//--- cnv_config_page_zero.sv
// Purpose: configuration page zero of a dual-channel interpolating converter
// Assumes: host reaches the registers over the serial link pins only
// Notes:   offset 00h and the page select at 1Fh answer on every page
`timescale 1ns/1ps
// Operation
// RQ1 - Host writes 01h at offset 0Bh of the selected page as the next-to-last start step.
// RQ2 - A write of 00h to offset 00h releases the receiver reset and starts conversion.
// RQ3 - Offset 00h holds wire count, register reset, number format, chip and bandgap power, reset 87h.
// RQ4 - Offset 01h holds oscillator, low-power oscillator, inverse sinc, modulation, interpolation.
// RQ5 - Offset 02h holds the clock multiplier bypass, power-downs, divider and phase, reset A1h.
// RQ6 - The 40-bit oscillator word spans 04h (low byte) to 08h (high byte).
// RQ7 - Oscillator bytes reset to 66h, except the top byte which resets to 26h.
// RQ8 - Offsets 09h and 0Ah hold a 13-bit phase correction plus its enable, reset zero.
// RQ9 - Channel A gain is 12 bits at 0Bh and 0Ch, resetting to 50h and 0Bh.
// RQ10 - Channel B gain is 12 bits at 0Dh and 0Eh with the same reset values.
// RQ11 - Offset 0Fh holds the two gain enables, the attenuation select and clipping, reset zero.
// RQ12 - Writing the register reset bit as 1 resets every register except offset 00h.
// RQ13 - The format bit selects two's complement at 0 and unsigned input at 1.
// RQ14 - With the oscillator disabled its phase accumulator is held at zero.
// RQ15 - Offset 1Fh holds a 3-bit page number selecting the addressed page, reset page 0.
// RQ16 - Offset 03h and unassigned bits read zero and ignore writes.
// RQ17 - A write takes effect on the clock after the serial write completes.
module cnv_config_page_zero
    import cnv_pkg::*;
(
    input  wire logic                       sys_clk,          // 200 MHz clock
    input  wire logic                       rst_b,            // async reset
    input  wire logic                       serClk,           // serial clock
    input  wire logic                       serSelB,          // select, low
    input  wire logic                       sdioIn,           // data pin in
    output logic                            sdioOut,          // data pin out
    output logic                            sdioOe,           // data pin drive
    output logic                            misoOut,          // 4-wire out
    output logic                            misoOe,           // 4-wire drive
    output logic                            receiverReset,    // lvds rx reset
    output logic                            threeWireSel,     // wire count
    output logic                            inputUnsigned,    // number format
    output logic                            chipPowerOn,      // chip power
    output logic                            bandgapPowerOn,   // bandgap power
    output logic                            oscEnable,        // oscillator on
    output logic                            oscPhaseClear,    // hold phase 0
    output logic [cnv_pkg::CNV_FREQ_W-1:0]  oscPhaseAcc,      // phase accum
    output logic                            lowPowerOscSel,   // low-power osc
    output logic                            inverseSincEn,    // inverse sinc
    output logic [2:0]                      modulationSel,    // modulation
    output logic [1:0]                      interpSel,        // interpolation
    output logic                            mulBypass,        // multiplier
    output logic                            mulBufferPd,      // buffer pd
    output logic                            mulLoopPd,        // loop pd
    output logic [1:0]                      mulDivider,       // divider
    output logic [1:0]                      mulPhase,         // phase
    output logic                            mulOscPd,         // osc pd
    output logic [cnv_pkg::CNV_FREQ_W-1:0]  oscFreqWord,      // freq word
    output logic [cnv_pkg::CNV_PHASE_W-1:0] phaseCorrValue,   // correction
    output logic                            phaseCorrEnable,  // correction on
    output logic [cnv_pkg::CNV_GAIN_W-1:0]  chanAGain,        // gain a
    output logic [cnv_pkg::CNV_GAIN_W-1:0]  chanBGain,        // gain b
    output logic                            chanAGainEnable,  // gain a on
    output logic                            chanBGainEnable,  // gain b on
    output logic                            outputAttenSel,   // minus 3 dB
    output logic                            outputClipEnable, // clipping
    output logic [cnv_pkg::CNV_PAGE_W-1:0]  pageSel           // page number
);
    import cnv_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // serial link

    logic [CNV_ADDR_W-1:0] regAddr;
    logic [CNV_DATA_W-1:0] rdData;
    logic [CNV_DATA_W-1:0] wrData;
    logic                  wrStrobe;
    logic                  serOut;
    logic                  serDrive;
    logic                  serIn;

    cnv_serial_link u_link (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .serClk   (serClk),
        .serSelB  (serSelB),
        .serIn    (serIn),
        .serOut   (serOut),
        .serDrive (serDrive),
        .regAddr  (regAddr),
        .rdData   (rdData),
        .wrStrobe (wrStrobe),
        .wrData   (wrData)
    );

    // both wire counts take write data on the shared data pin
    assign serIn = sdioIn;

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [CNV_DATA_W-1:0] regs_reg [CNV_NREG];
    logic [CNV_PAGE_W-1:0] page_reg;
    logic                  rxReset_reg;
    logic [CNV_FREQ_W-1:0] phaseAcc_reg;

    wire onPageZero = (page_reg == CNV_PAGE_RST);                      // see RQ15
    wire isCommon   = (regAddr == CNV_OFS_COMMON);
    wire isPage     = (regAddr == CNV_OFS_PAGE);
    wire inTable    = (regAddr[4] == 1'b0);
    wire tableHit   = inTable && (onPageZero || isCommon);             // see RQ15
    wire wrTable    = wrStrobe && tableHit;                            // see RQ17
    wire wrPage     = wrStrobe && isPage;
    wire softReset  = wrStrobe && isCommon && wrData[CNV_COM_RST];     // see RQ12
    wire wrCommon   = wrStrobe && isCommon;

    genvar gi;
    generate
        for (gi = 0; gi < CNV_NREG; gi++) begin : g_reg
            localparam logic [3:0] IDX = 4'(gi);
            wire hitMe = wrTable && (regAddr[3:0] == IDX);
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b)
                    regs_reg[gi] <= CNV_RST_VAL[gi];                   // see RQ3 RQ7
                else if (softReset && gi != 0)
                    regs_reg[gi] <= CNV_RST_VAL[gi];                   // see RQ12
                else if (hitMe)
                    regs_reg[gi] <= wrData & CNV_WR_MASK[gi];          // see RQ16
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            page_reg <= CNV_PAGE_RST;
        else if (softReset)
            page_reg <= CNV_PAGE_RST;                                  // see RQ12
        else if (wrPage)
            page_reg <= wrData[CNV_PAGE_W-1:0];                        // see RQ15
    end

    // receiver held in reset until the host clears the common register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            rxReset_reg <= 1'b1;
        else if (softReset)
            rxReset_reg <= 1'b1;
        else if (wrCommon && wrData == 8'h00)
            rxReset_reg <= 1'b0;                                       // see RQ2
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    wire [CNV_DATA_W-1:0] tableData = regs_reg[regAddr[3:0]];
    wire [CNV_DATA_W-1:0] pageData  = {{(CNV_DATA_W-CNV_PAGE_W){1'b0}}, page_reg};

    assign rdData = isPage   ? pageData  :
                    tableHit ? tableData : 8'h00;                      // see RQ16

    ////////////////////////////////////////////////////////////////////////////
    // pin steering by wire count

    wire threeWire = regs_reg[0][CNV_COM_WIRE];

    assign sdioOut = serOut;
    assign sdioOe  = serDrive && threeWire;                            // see RQ3
    assign misoOut = serOut;
    assign misoOe  = serDrive && !threeWire;

    ////////////////////////////////////////////////////////////////////////////
    // field decode

    wire [7:0] comReg = regs_reg[CNV_OFS_COMMON[3:0]];
    wire [7:0] txReg  = regs_reg[CNV_OFS_TRANSMIT_CONFIG[3:0]];
    wire [7:0] muReg  = regs_reg[CNV_OFS_MULCFG[3:0]];
    wire [7:0] phLo   = regs_reg[CNV_OFS_PHLO[3:0]];
    wire [7:0] phHi   = regs_reg[CNV_OFS_PHHI[3:0]];
    wire [7:0] agLo   = regs_reg[CNV_OFS_AGLO[3:0]];
    wire [7:0] agHi   = regs_reg[CNV_OFS_AGHI[3:0]];
    wire [7:0] bgLo   = regs_reg[CNV_OFS_BGLO[3:0]];
    wire [7:0] bgHi   = regs_reg[CNV_OFS_BGHI[3:0]];
    wire [7:0] ocReg  = regs_reg[CNV_OFS_OUTCTL[3:0]];

    assign receiverReset  = rxReset_reg;
    assign threeWireSel   = threeWire;
    assign inputUnsigned  = comReg[CNV_COM_FMT];                       // see RQ13
    assign chipPowerOn    = comReg[CNV_COM_CHIP];                      // see RQ3
    assign bandgapPowerOn = comReg[CNV_COM_GAP];
    assign pageSel        = page_reg;

    assign oscEnable      = txReg[CNV_TX_OSC];                         // see RQ4
    assign lowPowerOscSel = txReg[CNV_TX_LPOSC];
    assign inverseSincEn  = txReg[CNV_TX_ISINC];
    assign modulationSel  = txReg[CNV_TX_MOD+:3];
    assign interpSel      = txReg[CNV_TX_INTP+:2];

    assign mulBypass      = muReg[CNV_MU_BYP];                         // see RQ5
    assign mulBufferPd    = muReg[CNV_MU_BUF];
    assign mulLoopPd      = muReg[CNV_MU_LOOP];
    assign mulDivider     = muReg[CNV_MU_DIV+:2];
    assign mulPhase       = muReg[CNV_MU_PH+:2];
    assign mulOscPd       = muReg[CNV_MU_OSC];

    generate
        for (gi = 0; gi < CNV_FREQ_W / CNV_DATA_W; gi++) begin : g_freq
            assign oscFreqWord[gi*8 +: 8] = regs_reg[CNV_OFS_FREQ0[3:0] + gi]; // see RQ6
        end
    endgenerate

    assign phaseCorrValue  = {phHi[4:0], phLo};                        // see RQ8
    assign phaseCorrEnable = phHi[CNV_PH_EN];
    assign chanAGain       = {agHi[3:0], agLo};                        // see RQ9
    assign chanBGain       = {bgHi[3:0], bgLo};                        // see RQ10
    assign chanAGainEnable = ocReg[CNV_OC_AGE];                        // see RQ11
    assign chanBGainEnable = ocReg[CNV_OC_BGE];
    assign outputAttenSel  = ocReg[CNV_OC_ATT];
    assign outputClipEnable = ocReg[CNV_OC_CLIP];

    ////////////////////////////////////////////////////////////////////////////
    // oscillator phase accumulator

    wire                  accRun  = oscEnable && chipPowerOn && !rxReset_reg;
    wire [CNV_FREQ_W-1:0] accStep = oscFreqWord;

    assign oscPhaseClear = !oscEnable;                                 // see RQ14

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            phaseAcc_reg <= '0;
        else if (oscPhaseClear)
            phaseAcc_reg <= '0;                                        // see RQ14
        else if (accRun)
            phaseAcc_reg <= phaseAcc_reg + accStep;
    end

    assign oscPhaseAcc = phaseAcc_reg;
endmodule : cnv_config_page_zero

//--- cnv_config_page_zero_checker.sv
// Purpose: port-level assertions for configuration page zero
// Assumes: one clock domain, rst_b asynchronous active low
// Notes:   bound to the design from the testbench top file
`timescale 1ns/1ps
module cnv_config_page_zero_checker
    import cnv_pkg::*;
(
    input wire logic                           sys_clk,        // clock
    input wire logic                           rst_b,          // reset, low
    input wire logic                           serSelB,        // frame select
    input wire logic                           sdioOe,         // 3-wire drive
    input wire logic                           misoOe,         // 4-wire drive
    input wire logic                           receiverReset,  // rx reset
    input wire logic                           threeWireSel,   // wire count
    input wire logic                           chipPowerOn,    // chip power
    input wire logic                           bandgapPowerOn, // bandgap
    input wire logic                           oscEnable,      // osc on
    input wire logic                           oscPhaseClear,  // phase hold
    input wire logic [cnv_pkg::CNV_FREQ_W-1:0] oscPhaseAcc,    // accumulator
    input wire logic [cnv_pkg::CNV_FREQ_W-1:0] oscFreqWord,    // freq word
    input wire logic [cnv_pkg::CNV_GAIN_W-1:0] chanAGain,      // gain a
    input wire logic [cnv_pkg::CNV_PAGE_W-1:0] pageSel         // page
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_idle; serSelB ##1 serSelB; endsequence
    sequence s_oscOff; !oscEnable ##1 !oscEnable; endsequence
    sequence s_run; (oscEnable && chipPowerOn && !receiverReset) ##1 oscEnable; endsequence
    property p_rst_vals;
        $rose(rst_b) |-> receiverReset && pageSel == 3'h0 && oscFreqWord == 40'h2666666666;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    property p_soft_rst;
        $rose(receiverReset) |-> pageSel == 3'h0 && chanAGain == 12'hb50
            && oscFreqWord == 40'h2666666666;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete");
    property p_rx_rel;
        $fell(receiverReset) |-> !serSelB && {threeWireSel, chipPowerOn, bandgapPowerOn} == 3'h0;
    endproperty
    a_rx_rel: assert property (p_rx_rel) else $error("rx reset released wrongly");
    property p_osc_clr; s_oscOff |-> oscPhaseAcc == '0 && oscPhaseClear; endproperty
    a_osc_clr: assert property (p_osc_clr) else $error("phase not held at zero");
    property p_acc_add;
        s_run |-> oscPhaseAcc == $past(oscPhaseAcc) + $past(oscFreqWord);
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("phase step wrong");
    property p_quiet;
        s_idle |-> $stable(oscFreqWord) && $stable(pageSel) && $stable(chanAGain);
    endproperty
    a_quiet: assert property (p_quiet) else $error("register moved outside a frame");
    property p_oe_three; sdioOe |-> threeWireSel && !misoOe && !$past(serSelB); endproperty
    a_oe_three: assert property (p_oe_three) else $error("data pin drive wrong");
    property p_oe_four; misoOe |-> !threeWireSel && !$past(serSelB); endproperty
    a_oe_four: assert property (p_oe_four) else $error("4-wire drive wrong");
    property p_oe_off; s_idle |-> !sdioOe && !misoOe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive left on");
endmodule : cnv_config_page_zero_checker

//--- cnv_host_model.sv
// Purpose: host on the serial link, one byte access per frame
// Assumes: clock phases of two and three sys_clk cycles, mode 0
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
module cnv_host_model (
    input  wire logic sys_clk, // system clock
    input  wire logic sdioOut, // device data
    input  wire logic sdioOe,  // device drives data pin
    input  wire logic misoOut, // 4-wire data
    input  wire logic misoOe,  // 4-wire drive
    output logic      serClk,  // serial clock
    output logic      serSelB, // frame select, low
    output wire logic sdioIn   // resolved data pin
);
    logic hDrv = 1'b1;
    logic hBit = 1'b0;
    initial begin
        serClk = 1'b0;
        serSelB = 1'b1;
    end
    assign sdioIn = sdioOe ? sdioOut : (hDrv ? hBit : ~hBit);
    ////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic rd, input logic [4:0] adr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [15:0] frame;
        frame = {rd, 2'b00, adr, wd};
        rdat = 8'h00;
        @(posedge sys_clk);
        #1 serSelB = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            hDrv = !(rd && i < 8);
            if (hDrv)
                hBit = frame[i];
            repeat (2) @(posedge sys_clk);
            #1;
            if (i < 8)
                rdat[i] = sdioOe ? sdioOut : (misoOe ? misoOut : 1'bx);
            @(posedge sys_clk);
            #1 serClk = 1'b1;
            repeat (2) @(posedge sys_clk);
            #1 serClk = 1'b0;
        end
        repeat (2) @(posedge sys_clk);
        #1 serSelB = 1'b1;
        hDrv = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : xfer
endmodule : cnv_host_model

//--- testbench.sv
// Purpose: register bank test through the serial link host model
// Assumes: 200 MHz clock, 12-cycle reset at start
// Notes:   reads pick whichever data pin the device drives
`timescale 1ns/1ps
module testbench;
    import cnv_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    wire logic serClk, serSelB, sdioIn;
    logic sdioOut, sdioOe, misoOut, misoOe, receiverReset, threeWireSel, inputUnsigned;
    logic chipPowerOn, bandgapPowerOn, oscEnable, oscPhaseClear, lowPowerOscSel;
    logic inverseSincEn, mulBypass, mulBufferPd, mulLoopPd, mulOscPd, phaseCorrEnable;
    logic chanAGainEnable, chanBGainEnable, outputAttenSel, outputClipEnable;
    logic [2:0]             modulationSel, pageSel;
    logic [1:0]             interpSel, mulDivider, mulPhase;
    logic [CNV_FREQ_W-1:0]  oscPhaseAcc, oscFreqWord, accA;
    logic [CNV_PHASE_W-1:0] phaseCorrValue;
    logic [CNV_GAIN_W-1:0]  chanAGain, chanBGain;
    logic [7:0]             p [16];
    int errors = 0;
    int samples_checked = 0;
    localparam logic [7:0] expRst [16] = '{8'h87, 8'h01, 8'ha1, 8'h00, 8'h66, 8'h66, 8'h66,
        8'h66, 8'h26, 8'h00, 8'h00, 8'h50, 8'h0b, 8'h50, 8'h0b, 8'h00};
    localparam logic [7:0] expMask [16] = '{8'hc7, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h9f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h0f};
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    cnv_config_page_zero DUT (.sys_clk, .rst_b, .serClk, .serSelB, .sdioIn, .sdioOut, .sdioOe,
        .misoOut, .misoOe, .receiverReset, .threeWireSel, .inputUnsigned, .chipPowerOn,
        .bandgapPowerOn, .oscEnable, .oscPhaseClear, .oscPhaseAcc, .lowPowerOscSel,
        .inverseSincEn, .modulationSel, .interpSel, .mulBypass, .mulBufferPd, .mulLoopPd,
        .mulDivider, .mulPhase, .mulOscPd, .oscFreqWord, .phaseCorrValue, .phaseCorrEnable,
        .chanAGain, .chanBGain, .chanAGainEnable, .chanBGainEnable, .outputAttenSel,
        .outputClipEnable, .pageSel);
    cnv_host_model host (.sys_clk, .sdioOut, .sdioOe, .misoOut, .misoOe, .serClk, .serSelB,
        .sdioIn);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [4:0] adr, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, adr, d, unused);
    endtask : wr
    task automatic rd(input logic [4:0] adr, input logic [7:0] exp);
        logic [7:0] v;
        host.xfer(1'b1, adr, 8'h00, v);
        chk($sformatf("read %h", adr), v, exp);
    endtask : rd
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        test_done();
    end
    initial begin
        for (int i = 0; i < 16; i++)
            p[i] = 8'(i * 29 + 53);
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        for (int i = 0; i <= 16; i++)
            rd(5'(i), (i < 16) ? expRst[i[3:0]] : 8'h00);
        $display("test reset values done");
        for (int i = 1; i < 16; i++)
            wr(5'(i), p[i]);
        for (int i = 1; i < 16; i++)
            rd(5'(i), p[i] & expMask[i[3:0]]);
        chk("tx", {oscEnable, lowPowerOscSel, inverseSincEn, modulationSel, interpSel},
            p[1]);
        chk("mul", {mulBypass, mulBufferPd, mulLoopPd, mulDivider, mulPhase, mulOscPd},
            p[2]);
        chk("freq", oscFreqWord, {p[8], p[7], p[6], p[5], p[4]});
        chk("phase", {phaseCorrEnable, phaseCorrValue}, {p[10][7], p[10][4:0], p[9]});
        chk("gain a", chanAGain, {p[12][3:0], p[11]});
        chk("gain b", chanBGain, {p[14][3:0], p[13]});
        chk("out", {chanAGainEnable, chanBGainEnable, outputAttenSel, outputClipEnable},
            p[15][3:0]);
        $display("test write fields done");
        wr(5'h1f, 8'h02);
        rd(5'h1f, 8'h02);
        rd(5'h0b, 8'h00);
        wr(5'h0b, 8'h01);
        wr(5'h1f, 8'h00);
        rd(5'h0b, p[11]);
        wr(5'h1f, 8'h05);
        wr(5'h00, 8'h47);
        chk("page", pageSel, 3'h0);
        chk("rx reset", receiverReset, 1'b1);
        rd(5'h0b, 8'h50);
        rd(5'h00, 8'h47);
        $display("test page and soft reset done");
        wr(5'h0b, 8'h01);
        rd(5'h0b, 8'h01);
        wr(5'h00, 8'h00);
        chk("rx release", {receiverReset, chipPowerOn}, 2'b00);
        wr(5'h01, 8'h86);
        wr(5'h00, 8'h07);
        chk("common", {threeWireSel, inputUnsigned, chipPowerOn, bandgapPowerOn, receiverReset},
            5'h0e);
        accA = oscPhaseAcc;
        @(posedge sys_clk);
        #1;
        chk("phase step", 40'(oscPhaseAcc - accA), 40'h2666666666);
        wr(5'h01, 8'h06);
        chk("phase held", {oscPhaseAcc, oscPhaseClear}, {40'h0, 1'b1});
        wr(5'h00, 8'h47);
        chk("rx reassert", receiverReset, 1'b1);
        chk("gain reset", chanAGain, 12'hb50);
        $display("test start-up tail done");
        test_done();
    end
endmodule : testbench
bind cnv_config_page_zero cnv_config_page_zero_checker u_chk (.sys_clk, .rst_b, .serSelB,
    .sdioOe, .misoOe, .receiverReset, .threeWireSel, .chipPowerOn, .bandgapPowerOn,
    .oscEnable, .oscPhaseClear, .oscPhaseAcc, .oscFreqWord, .chanAGain, .pageSel);
